// >>> rtl/pcr_top.sv
// core clock generation and reset release with an AXI4-Lite control port
// How it works
// - oscillator ratio reported as two times effective multiplier over input stage.
// - core clock is oscillator divided by twice the post-divide factor 1/2/4/8.
// - during reset the multiplier comes from the ratio pins, not software.
// - during reset the post-divide factor is forced to one.
// - input stage passes reference clock when halve bit is 0, halves when 1.
// - peripheral clock period is twice the core clock period.
// - core reset held 4096 reference periods plus two core periods after pin release.
// - a missed setup window may add one reference cycle, 4097 at most.
// - a test clock output follows the input stage frequency, not for use.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module pcr_top #(
  parameter int REF_HOLD = pcr_pkg::REF_HOLD_CYCLES
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic REF_CLOCK_IN,
  input wire logic RESET_PIN_N,
  input wire logic [1:0] RATIO_SELECT,
  output logic CORE_CLOCK,
  output logic PERIPHERAL_CLOCK,
  output logic TEST_CLOCK_OUTPUT,
  output logic CORE_RESET,
  input wire logic [pcr_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [pcr_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  localparam logic [pcr_pkg::HOLD_W-1:0] REF_LAST = pcr_pkg::HOLD_W'(REF_HOLD - 1);

  // pins cross in through two flops before any use
  logic [3:0] pins_sync;
  pcr_sync #(.WIDTH(4)) u_sync (
    .clk(CLK),
    .din({RATIO_SELECT, RESET_PIN_N, REF_CLOCK_IN}),
    .dout(pins_sync)
  );
  logic ref_s;
  logic pin_rst;
  logic [1:0] ratio_s;
  assign ref_s = pins_sync[0];
  assign pin_rst = ~pins_sync[1];
  assign ratio_s = pins_sync[3:2];

  // software control
  logic [pcr_pkg::MULT_W-1:0] pll_multiplier, next_pll_multiplier;
  logic [1:0] post_divide_select, next_post_divide_select;
  logic input_halve_enable, next_input_halve_enable;

  // input stage and effective settings
  logic ref_prev, next_ref_prev;
  logic halve_ff, next_halve_ff;
  logic input_rise;
  logic [pcr_pkg::MULT_W-1:0] eff_mult;
  logic [pcr_pkg::FACT_W-1:0] post_divide_factor;
  logic [pcr_pkg::MULT_W-1:0] pin_mult;

  always_comb
  begin
    case (ratio_s)
      2'h0: pin_mult = pcr_pkg::PIN_MULT_00;
      2'h1: pin_mult = pcr_pkg::PIN_MULT_01;
      2'h2: pin_mult = pcr_pkg::PIN_MULT_10;
      default: pin_mult = pcr_pkg::PIN_MULT_11;
    endcase
    eff_mult = pin_rst ? pin_mult : pll_multiplier;
    post_divide_factor = pin_rst ? pcr_pkg::FACT_ONE
                       : pcr_pkg::FACT_ONE << post_divide_select;
    next_ref_prev = ref_s;
    next_halve_ff = halve_ff;
    if (ref_s && !ref_prev)
    begin
      next_halve_ff = ~halve_ff;
    end
    next_ref_prev = ref_s;
  end
  // the pass-through path follows the reference; halved path toggles per rising ref edge
  assign input_rise = ref_s && !ref_prev;

  // core clock: CLK stands in for the oscillator, halfperiod = factor cycles
  logic [pcr_pkg::FACT_W-1:0] div_cnt, next_div_cnt;
  logic core_clk, next_core_clk;
  logic per_clk, next_per_clk;
  logic test_clk, next_test_clk;
  logic core_rise;
  always_comb
  begin
    next_div_cnt = div_cnt + pcr_pkg::FACT_W'(1);
    next_core_clk = core_clk;
    next_per_clk = per_clk;
    core_rise = 1'b0;
    if (div_cnt >= post_divide_factor - pcr_pkg::FACT_ONE)
    begin
      next_div_cnt = '0;
      next_core_clk = ~core_clk;
      core_rise = !core_clk;
    end
    if (core_rise)
    begin
      next_per_clk = ~per_clk;
    end
    next_test_clk = input_halve_enable ? halve_ff : ref_s;
  end

  // core reset release sequencer
  pcr_pkg::pcr_state_t state, next_state;
  logic [pcr_pkg::HOLD_W-1:0] hold_cnt, next_hold_cnt;
  always_comb
  begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    if (pin_rst)
    begin
      next_state = pcr_pkg::ST_HELD;
      next_hold_cnt = '0;
    end
    else
    begin
      case (state)
        pcr_pkg::ST_HELD:
        begin
          next_state = pcr_pkg::ST_REF_WAIT;
          next_hold_cnt = '0;
        end
        pcr_pkg::ST_REF_WAIT:
          if (input_rise)
          begin
            next_hold_cnt = hold_cnt + pcr_pkg::HOLD_W'(1);
            if (hold_cnt == REF_LAST)
            begin
              next_state = pcr_pkg::ST_CORE_WAIT;
              next_hold_cnt = '0;
            end
          end
        pcr_pkg::ST_CORE_WAIT:
          if (core_rise)
          begin
            next_hold_cnt = hold_cnt + pcr_pkg::HOLD_W'(1);
            if (hold_cnt[1:0] == pcr_pkg::CORE_HOLD_CYCLES - 2'h1)
            begin
              next_state = pcr_pkg::ST_RUN;
            end
          end
        pcr_pkg::ST_RUN: next_state = pcr_pkg::ST_RUN;
        default: next_state = pcr_pkg::ST_HELD;
      endcase
    end
  end

  // AXI4-Lite slave: address and data latched in either order
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [pcr_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [31:0] ctrl_word, status_word;

  assign S_AXI_AWREADY = !aw_held && !bvalid;
  assign S_AXI_WREADY = !w_held && !bvalid;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RRESP = rresp;
  assign S_AXI_RDATA = rdata;

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[pcr_pkg::CTRL_MULT_LSB +: pcr_pkg::MULT_W] = pll_multiplier;
    ctrl_word[pcr_pkg::CTRL_DIV_LSB +: 2] = post_divide_select;
    ctrl_word[pcr_pkg::CTRL_HALVE_BIT] = input_halve_enable;
    status_word = '0;
    status_word[pcr_pkg::STAT_MULT_LSB +: pcr_pkg::MULT_W] = eff_mult;
    status_word[pcr_pkg::STAT_FACT_LSB +: pcr_pkg::FACT_W] = post_divide_factor;
    status_word[pcr_pkg::STAT_CORE_RST_BIT] = CORE_RESET;
    status_word[pcr_pkg::STAT_PIN_RST_BIT] = pin_rst;
    // oscillator over input-stage ratio, shown to software for limit checks
    status_word[pcr_pkg::STAT_RATIO_LSB +: 8] = 8'(pcr_pkg::VCO_FACTOR * eff_mult);
  end

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_pll_multiplier = pll_multiplier;
    next_post_divide_select = post_divide_select;
    next_input_halve_enable = input_halve_enable;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      next_w_held = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
    end
    if (aw_held && w_held)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = pcr_pkg::RESP_OKAY;
      if (aw_addr == pcr_pkg::ADDR_CTRL)
      begin
        if (w_strb[0])
        begin
          next_pll_multiplier = w_data[pcr_pkg::CTRL_MULT_LSB +: pcr_pkg::MULT_W];
        end
        if (w_strb[1])
        begin
          next_post_divide_select = w_data[pcr_pkg::CTRL_DIV_LSB +: 2];
          next_input_halve_enable = w_data[pcr_pkg::CTRL_HALVE_BIT];
        end
      end
      else if (aw_addr != pcr_pkg::ADDR_STATUS)
      begin
        next_bresp = pcr_pkg::RESP_SLVERR;
      end
    end
    else if (bvalid && S_AXI_BREADY)
    begin
      next_bvalid = 1'b0;
    end
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      next_rvalid = 1'b1;
      next_rresp = pcr_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        pcr_pkg::ADDR_CTRL: next_rdata = ctrl_word;
        pcr_pkg::ADDR_STATUS: next_rdata = status_word;
        default:
        begin
          next_rdata = '0;
          next_rresp = pcr_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && S_AXI_RREADY)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pll_multiplier <= pcr_pkg::MULT_RESET;
      post_divide_select <= pcr_pkg::DIV_RESET;
      input_halve_enable <= pcr_pkg::HALVE_RESET;
      ref_prev <= 1'b0;
      halve_ff <= 1'b0;
      div_cnt <= '0;
      core_clk <= 1'b0;
      per_clk <= 1'b0;
      test_clk <= 1'b0;
      state <= pcr_pkg::ST_HELD;
      hold_cnt <= '0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= pcr_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= pcr_pkg::RESP_OKAY;
      rdata <= '0;
    end
    else
    begin
      pll_multiplier <= next_pll_multiplier;
      post_divide_select <= next_post_divide_select;
      input_halve_enable <= next_input_halve_enable;
      ref_prev <= next_ref_prev;
      halve_ff <= next_halve_ff;
      div_cnt <= next_div_cnt;
      core_clk <= next_core_clk;
      per_clk <= next_per_clk;
      test_clk <= next_test_clk;
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  assign CORE_CLOCK = core_clk;
  assign PERIPHERAL_CLOCK = per_clk;
  assign TEST_CLOCK_OUTPUT = test_clk;
  assign CORE_RESET = (state != pcr_pkg::ST_RUN);
endmodule

// >>> rtl/pcr_pkg.sv
// shared constants for the core clock and reset release block
package pcr_pkg;
  localparam int ADDR_W = 8;
  localparam int MULT_W = 7;
  localparam int FACT_W = 4;
  localparam int HOLD_W = 13;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RATIO = 8'h08;
  // control register layout
  localparam int CTRL_MULT_LSB = 0;
  localparam int CTRL_DIV_LSB = 8;
  localparam int CTRL_HALVE_BIT = 10;
  // status register layout
  localparam int STAT_MULT_LSB = 0;
  localparam int STAT_FACT_LSB = 8;
  localparam int STAT_CORE_RST_BIT = 12;
  localparam int STAT_PIN_RST_BIT = 13;
  localparam int STAT_RATIO_LSB = 16;
  localparam logic [MULT_W-1:0] MULT_RESET = 7'h10;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic HALVE_RESET = 1'b0;
  localparam logic [FACT_W-1:0] FACT_ONE = 4'h1;
  // multiplier picked by the two ratio pins during reset
  localparam logic [MULT_W-1:0] PIN_MULT_00 = 7'h06;
  localparam logic [MULT_W-1:0] PIN_MULT_01 = 7'h20;
  localparam logic [MULT_W-1:0] PIN_MULT_10 = 7'h10;
  localparam logic [MULT_W-1:0] PIN_MULT_11 = 7'h06;
  localparam int VCO_FACTOR = 2;
  localparam int REF_HOLD_CYCLES = 4096;
  localparam logic [1:0] CORE_HOLD_CYCLES = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_HELD = 4'h1,
    ST_REF_WAIT = 4'h2,
    ST_CORE_WAIT = 4'h4,
    ST_RUN = 4'h8
  } pcr_state_t;
endpackage

// >>> rtl/pcr_sync.sv
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/10ps
module pcr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        meta[i] <= din[i];
        dout[i] <= meta[i];
      end
    end
  endgenerate
endmodule

// >>> verif/pcr_monitor.sv
// port-level checks for the clock and reset release block
`timescale 1ns/10ps
module pcr_monitor (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic RESET_PIN_N,
  input wire logic CORE_CLOCK,
  input wire logic PERIPHERAL_CLOCK,
  input wire logic CORE_RESET,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  a_rst_held: assert property (!RESET_PIN_N [*4] |-> CORE_RESET)
    else $error("core reset low while pin low");
  a_hold_min: assert property ($rose(RESET_PIN_N) |-> CORE_RESET [*8])
    else $error("core reset released early");
  a_hold_end: assert property ($rose(RESET_PIN_N) |-> ##[60:300] !CORE_RESET)
    else $error("core reset never released");
  // the pin reaches the factor through the two-flop synchroniser, so allow eight cycles
  a_fact_one: assert property (!RESET_PIN_N [*8] |-> $changed(CORE_CLOCK))
    else $error("core clock not at factor one");
  a_pclk_follow: assert property ($rose(CORE_CLOCK) |-> ##[0:1] $changed(PERIPHERAL_CLOCK))
    else $error("peripheral clock missed a core rise");
  a_bresp_time: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  a_rdata_time: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  a_aw_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
endmodule
bind pcr_top pcr_monitor pcr_monitor_inst (.CLK(CLK), .SRST(SRST),
  .RESET_PIN_N(RESET_PIN_N), .CORE_CLOCK(CORE_CLOCK), .PERIPHERAL_CLOCK(PERIPHERAL_CLOCK),
  .CORE_RESET(CORE_RESET), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID));

// >>> verif/pcr_board_model.sv
// board side: reference oscillator, ratio pins and reset source
`timescale 1ns/10ps
module pcr_board_model (
  input wire logic hold_reset,
  input wire logic [1:0] ratio_req,
  output logic ref_clk,
  output logic reset_n,
  output logic [1:0] ratio_pins
);
  realtime t_chg = 0.0;
  int low_cnt = 0;
  initial
  begin
    ref_clk = 1'h0;
    reset_n = 1'h0;
    #7;
    forever #20 ref_clk = ~ref_clk;
  end
  assign ratio_pins = ratio_req;
  always @(ratio_req) t_chg = $realtime;
  // release waits for settled pins and a running oscillator
  always @(posedge ref_clk or posedge hold_reset)
    if (hold_reset)
    begin
      reset_n <= 1'h0;
      low_cnt <= 0;
    end
    else if (low_cnt < 4 || $realtime < t_chg + 20000.0 || $realtime < 10010.0)
      low_cnt <= low_cnt + 1;
    else
      reset_n <= 1'h1;
endmodule

// >>> verif/pll_clock_and_reset_release_bench.sv
// self-checking bench for the core clock and reset release block
`timescale 1ns/10ps
module pll_clock_and_reset_release_bench;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic hold_reset = 1'h1;
  logic [1:0] ratio_req = 2'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, core_clock, peri_clock, test_clock;
  logic core_reset, ref_clk, reset_n;
  logic [1:0] bresp, rresp, rs, ratio_pins;
  int n_errors = 0;
  int cmp_count = 0;
  int n;
  logic [6:0] pin_tab [4] = '{pcr_pkg::PIN_MULT_00, pcr_pkg::PIN_MULT_01,
    pcr_pkg::PIN_MULT_10, pcr_pkg::PIN_MULT_11};
  pcr_board_model pcr_board_model_inst (.hold_reset(hold_reset), .ratio_req(ratio_req),
    .ref_clk(ref_clk), .reset_n(reset_n), .ratio_pins(ratio_pins));
  pcr_top #(.REF_HOLD(8)) pcr_top_inst (.CLK(clk), .SRST(srst), .REF_CLOCK_IN(ref_clk),
    .RESET_PIN_N(reset_n), .RATIO_SELECT(ratio_pins), .CORE_CLOCK(core_clock),
    .PERIPHERAL_CLOCK(peri_clock), .TEST_CLOCK_OUTPUT(test_clock), .CORE_RESET(core_reset),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  initial forever #2 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one access; each channel drops valid at its own ready edge
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    do
    begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (arready) arvalid <= 1'h0;
    end while (!(bready && bvalid) && !(rready && rvalid) && t < 100);
    rs = wr ? bresp : rresp;
    rd = rdata;
    bready <= 1'h0;
    rready <= 1'h0;
    check(t < 100, 1);
  endtask
  function automatic logic pick(input int sel);
    return sel == 0 ? core_clock : sel == 1 ? peri_clock : test_clock;
  endfunction
  // sampled 1 ns after the edge so the outputs have settled
  task automatic count_toggles(input int sel, input int win);
    logic prev;
    n = 0;
    @(posedge clk);
    #1;
    prev = pick(sel);
    repeat (win)
    begin
      @(posedge clk);
      #1;
      if (pick(sel) !== prev) n++;
      prev = pick(sel);
    end
  endtask
  task automatic release_pin;
    int t;
    t = 0;
    hold_reset <= 1'h0;
    while (reset_n !== 1'h1 && t < 8000)
    begin
      @(posedge clk);
      t++;
    end
    t = 0;
    while (core_reset !== 1'h0 && t < 400)
    begin
      @(posedge clk);
      t++;
    end
    check(t >= 70 && t < 250, 1);
  endtask
  initial
  begin
    #200us;
    n_errors++;
    test_done();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    axi(1'h0, pcr_pkg::ADDR_CTRL, 32'h0);
    check(rd, {21'h0, pcr_pkg::HALVE_RESET, pcr_pkg::DIV_RESET, 1'h0, pcr_pkg::MULT_RESET});
    check(rs, pcr_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      ratio_req <= i[1:0];
      repeat (8) @(posedge clk);
      axi(1'h0, pcr_pkg::ADDR_STATUS, 32'h0);
      check(rd[6:0], pin_tab[i]);
      check(rd[23:16], {pin_tab[i], 1'h0});
      check(rd[12:8], 5'h11);
    end
    axi(1'h1, pcr_pkg::ADDR_CTRL, 32'h310);
    check(rs, pcr_pkg::RESP_OKAY);
    axi(1'h0, pcr_pkg::ADDR_STATUS, 32'h0);
    check(rd[11:0], {4'h1, 1'h0, pin_tab[3]});
    $display("end: ratio pins in reset");
    release_pin();
    $display("end: first release");
    for (int k = 0; k < 4; k++)
    begin
      axi(1'h1, pcr_pkg::ADDR_CTRL, {22'h0, k[1:0], 8'h10});
      repeat (40) @(posedge clk);
      axi(1'h0, pcr_pkg::ADDR_STATUS, 32'h0);
      check(rd[12:0], {1'h0, 4'h1 << k, 1'h0, 7'h10});
      count_toggles(0, 128);
      check(n, 128 >> k);
      count_toggles(1, 128);
      check(n, 64 >> k);
    end
    $display("end: post divide");
    for (int h = 0; h < 2; h++)
    begin
      axi(1'h1, pcr_pkg::ADDR_CTRL, {21'h0, h[0], 10'h010});
      count_toggles(2, 400);
      check(n >= (79 >> h) && n <= (81 >> h) + 1, 1);
    end
    $display("end: input halve");
    axi(1'h0, 8'h0C, 32'h0);
    check(rs, pcr_pkg::RESP_SLVERR);
    check(rd, 32'h0);
    axi(1'h1, 8'h0C, 32'h5);
    check(rs, pcr_pkg::RESP_SLVERR);
    axi(1'h1, pcr_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    check(rs, pcr_pkg::RESP_OKAY);
    $display("end: bus errors");
    hold_reset <= 1'h1;
    repeat (10) @(posedge clk);
    axi(1'h0, pcr_pkg::ADDR_STATUS, 32'h0);
    check(rd[13:0], {6'h31, 1'h0, pin_tab[3]});
    release_pin();
    $display("end: second reset");
    test_done();
  end
endmodule
